// [hdl/vps_defs.svh]
`ifndef VPS_DEFS_SVH
`define VPS_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define VPS_CLK_PERIOD_NS 50
`define VPS_VID_HOLD_NS 400
`define VPS_VID_HOLD_CYC ((`VPS_VID_HOLD_NS + `VPS_CLK_PERIOD_NS - 1) / `VPS_CLK_PERIOD_NS)
`define VPS_PG_MASK_US 130
`define VPS_PG_MASK_CYC ((`VPS_PG_MASK_US * 1000) / `VPS_CLK_PERIOD_NS)
`define VPS_LATCHOFF_US 100
`define VPS_LATCHOFF_CYC ((`VPS_LATCHOFF_US * 1000) / `VPS_CLK_PERIOD_NS)
`define VPS_TMR_W 12

// ----------------------------------------
// Code thresholds
// ----------------------------------------
`define VPS_VID_300MV 7'h60

// ----------------------------------------
// Register map
// ----------------------------------------
`define VPS_ADDR_CTRL 4'h0
`define VPS_ADDR_STATUS 4'h4
`define VPS_ADDR_VID 4'h8
`define VPS_CTRL_RST 1'h0
`define VPS_CTRL_MULTI_BIT 0
`define VPS_RESP_OKAY 2'h0
`define VPS_RESP_SLVERR 2'h2

`endif

// [hdl/vps_pkg.sv]
package vps_pkg;

    // Control state, Gray along OFF -> RUN -> OVP
    typedef enum logic [1:0] {
        VPS_ST_OFF = 2'h0,
        VPS_ST_RUN = 2'h1,
        VPS_ST_OVP = 2'h3
    } vps_state_t;

    // Analog comparator results
    typedef struct packed {
        logic supply_ok;
        logic supply_uv;
        logic ovp_trip;
        logic tt_disable;
        logic rvp_enter;
        logic rvp_exit;
        logic therm_hi;
        logic therm_lo;
        logic current_limit_set_over;
        logic light_load;
        logic pg_upper_ok;
        logic pg_lower_ok;
        logic [1:0] zero_cross;
    } vps_cmp_t;

endpackage

// [hdl/vps_seq.sv]
`timescale 1ns/100ps
`include "vps_defs.svh"
module vps_seq (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [6:0] voltage_id_code_in,
    input wire logic deeper_sleep_select_in,
    input wire logic enable_in,
    input wire vps_pkg::vps_cmp_t cmp_in,
    input wire logic [1:0] pwm_in,
    input wire logic power_good_in,
    output logic power_good_data_out,
    output logic power_good_oe_n_out,
    output logic high_side_gate_drive_a_out,
    output logic high_side_gate_drive_b_out,
    output logic low_side_gate_drive_a_out,
    output logic low_side_gate_drive_b_out,
    output logic ripple_regulation_mode_out,
    output logic dual_phase_out,
    output logic thermal_alarm_out,
    output logic current_limit_out,
    output logic soft_start_discharge_out,
    output logic power_good_delay_discharge_out
);
    import vps_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    localparam int unsigned SW = $bits(vps_cmp_t) + 9;
    logic [SW-1:0] sync_v;
    vps_cmp_t cmp_s;
    logic [6:0] vid_s;
    logic dsleep_s;
    logic en_s;

    vps_sync #(.W(SW)) u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in({cmp_in, voltage_id_code_in, deeper_sleep_select_in, enable_in}),
        .sync_out(sync_v)
    );
    assign {cmp_s, vid_s, dsleep_s, en_s} = sync_v;

    // ----------------------------------------
    // Code tracking and masking
    // ----------------------------------------
    logic [6:0] vid_prev_q;
    logic [6:0] vid_acc_q;
    logic dsleep_prev_q;
    logic vid_chg;
    logic sleep_chg;
    logic hold_busy;
    logic hold_done;
    logic mask_busy;
    logic transient;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            vid_prev_q <= 7'h00;
            dsleep_prev_q <= 1'h0;
        end else begin
            vid_prev_q <= vid_s;
            dsleep_prev_q <= dsleep_s;
        end
    end

    assign vid_chg = (vid_s != vid_prev_q);
    assign sleep_chg = (dsleep_s != dsleep_prev_q);

    vps_timer #(.W(`VPS_TMR_W)) u_hold (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(vid_chg),
        .load_in(`VPS_TMR_W'(`VPS_VID_HOLD_CYC)),
        .busy_out(hold_busy),
        .done_out(hold_done)
    );

    vps_timer #(.W(`VPS_TMR_W)) u_mask (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(vid_chg || sleep_chg),
        .load_in(`VPS_TMR_W'(`VPS_PG_MASK_CYC)),
        .busy_out(mask_busy),
        .done_out()
    );

    assign transient = hold_busy || mask_busy;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            vid_acc_q <= 7'h00;
        end else if (hold_done) begin
            vid_acc_q <= vid_s;
        end
    end

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    vps_state_t st_q;
    logic [0:0] ctrl_q;
    logic multi_cfg;
    logic rvp_q;
    logic therm_q;
    logic current_limit_set_q;
    logic current_limit_set_force_q;
    logic latch_done;

    assign multi_cfg = ctrl_q[`VPS_CTRL_MULTI_BIT];

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_q <= VPS_ST_OFF;
        end else begin
            case (st_q)
                VPS_ST_OFF: begin
                    if (en_s && cmp_s.supply_ok && !cmp_s.supply_uv) begin
                        st_q <= VPS_ST_RUN;
                    end
                end
                VPS_ST_RUN: begin
                    if (!en_s || cmp_s.supply_uv) begin
                        st_q <= VPS_ST_OFF;
                    end else if (cmp_s.ovp_trip && !cmp_s.tt_disable) begin
                        st_q <= VPS_ST_OVP;
                    end
                end
                // latched until enable low or supply loss
                VPS_ST_OVP: begin
                    if (!en_s || cmp_s.supply_uv) begin
                        st_q <= VPS_ST_OFF;
                    end
                end
                default: begin
                    st_q <= VPS_ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rvp_q <= 1'h0;
        end else if (st_q != VPS_ST_OFF && cmp_s.rvp_enter) begin
            rvp_q <= 1'h1;
        end else if (st_q == VPS_ST_OFF || cmp_s.rvp_exit) begin
            rvp_q <= 1'h0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            therm_q <= 1'h0;
        end else if (cmp_s.therm_hi) begin
            therm_q <= 1'h1;
        end else if (cmp_s.therm_lo) begin
            therm_q <= 1'h0;
        end
    end

    vps_timer #(.W(`VPS_TMR_W)) u_latch (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(cmp_s.current_limit_set_over && !current_limit_set_force_q && multi_cfg),
        .load_in(`VPS_TMR_W'(`VPS_LATCHOFF_CYC)),
        .busy_out(),
        .done_out(latch_done)
    );

    // limit flag and forced dual phase
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            current_limit_set_q <= 1'h0;
            current_limit_set_force_q <= 1'h0;
        end else begin
            current_limit_set_q <= cmp_s.current_limit_set_over;
            if (cmp_s.current_limit_set_over && multi_cfg && st_q == VPS_ST_RUN) begin
                current_limit_set_force_q <= 1'h1;
            end else if (latch_done || st_q == VPS_ST_OFF) begin
                current_limit_set_force_q <= 1'h0;
            end
        end
    end

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    logic dual_q;
    logic rpm_q;
    logic dcm_q;
    logic dual_d;

    assign dual_d = transient || current_limit_set_force_q || (multi_cfg && !cmp_s.light_load);

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            dual_q <= 1'h0;
            rpm_q <= 1'h0;
            dcm_q <= 1'h0;
        end else begin
            dual_q <= dual_d;
            rpm_q <= (!multi_cfg || dsleep_s) && !transient;
            // light-load discontinuous only in deeper sleep
            dcm_q <= dsleep_s && !transient && cmp_s.light_load && !dual_d;
        end
    end

    // ----------------------------------------
    // Gate drives
    // ----------------------------------------
    function automatic logic [1:0] drive_fn(input vps_state_t st, input logic reverse_voltage_protect,
                                            input logic act, input logic pwm,
                                            input logic ls_cut);
        logic [1:0] r;
        r = 2'h0;
        if (st == VPS_ST_OFF || reverse_voltage_protect) begin
            r = 2'h0;
        end else if (st == VPS_ST_OVP) begin
            r = 2'h1;
        end else if (act) begin
            r = {pwm, !pwm && !ls_cut};
        end
        return r;
    endfunction

    logic [1:0] hs_v;
    logic [1:0] ls_v;

    for (genvar i = 0; i < 2; i++) begin : g_ph
        logic zc_q;
        logic hs_q;
        logic ls_q;
        logic cut;

        // hold low side off after zero crossing
        always_ff @(posedge core_clk_in) begin
            if (rst_in || pwm_in[i]) begin
                zc_q <= 1'h0;
            end else if (cmp_s.zero_cross[i]) begin
                zc_q <= 1'h1;
            end
        end

        assign cut = dcm_q && (zc_q || cmp_s.zero_cross[i]);

        always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
                hs_q <= 1'h0;
                ls_q <= 1'h0;
            end else begin
                {hs_q, ls_q} <= drive_fn(st_q, rvp_q, (i == 0) || dual_q, pwm_in[i], cut);
            end
        end

        assign hs_v[i] = hs_q;
        assign ls_v[i] = ls_q;
    end

    // ----------------------------------------
    // Power good and shutdown outputs
    // ----------------------------------------
    logic pg_q;
    logic dis_q;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pg_q <= 1'h0;
            dis_q <= 1'h1;
        end else begin
            pg_q <= (st_q == VPS_ST_RUN) && !transient && cmp_s.pg_upper_ok &&
                    (cmp_s.pg_lower_ok || (vid_acc_q > `VPS_VID_300MV));
            dis_q <= (st_q == VPS_ST_OFF);
        end
    end

    assign power_good_data_out = 1'h0;
    assign power_good_oe_n_out = pg_q;
    assign high_side_gate_drive_a_out = hs_v[0];
    assign high_side_gate_drive_b_out = hs_v[1];
    assign low_side_gate_drive_a_out = ls_v[0];
    assign low_side_gate_drive_b_out = ls_v[1];
    assign ripple_regulation_mode_out = rpm_q;
    assign dual_phase_out = dual_q;
    assign thermal_alarm_out = therm_q;
    assign current_limit_out = current_limit_set_q;
    assign soft_start_discharge_out = dis_q;
    assign power_good_delay_discharge_out = dis_q;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        logic [1:0] s;
        s = 2'h3;
        if (addr[31:4] == 28'h0) begin
            case (addr[3:0])
                `VPS_ADDR_CTRL: s = 2'h0;
                `VPS_ADDR_STATUS: s = 2'h1;
                `VPS_ADDR_VID: s = 2'h2;
                default: s = 2'h3;
            endcase
        end
        return s;
    endfunction

    logic aw_q;
    logic w_q;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [31:0] status_v;

    assign status_v = {20'h0, power_good_in, pg_q, dcm_q, rpm_q, dual_q, current_limit_set_force_q,
                       current_limit_set_q, therm_q, rvp_q, transient, st_q};

    assign s_axi_awready_out = !aw_q && !bvalid_q;
    assign s_axi_wready_out = !w_q && !bvalid_q;
    assign s_axi_arready_out = !rvalid_q;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            aw_q <= 1'h0;
            w_q <= 1'h0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'h0;
            bvalid_q <= 1'h0;
            bresp_q <= `VPS_RESP_OKAY;
            ctrl_q <= `VPS_CTRL_RST;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_q <= 1'h1;
                awaddr_q <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_q <= 1'h1;
                wdata_q <= s_axi_wdata_in;
                wstrb0_q <= s_axi_wstrb_in[0];
            end
            if (aw_q && w_q) begin
                aw_q <= 1'h0;
                w_q <= 1'h0;
                bvalid_q <= 1'h1;
                bresp_q <= (reg_sel(awaddr_q) == 2'h3) ? `VPS_RESP_SLVERR : `VPS_RESP_OKAY;
                if (reg_sel(awaddr_q) == 2'h0 && wstrb0_q) begin
                    ctrl_q <= wdata_q[0:0];
                end
            end else if (bvalid_q && s_axi_bready_in) begin
                bvalid_q <= 1'h0;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rvalid_q <= 1'h0;
            rresp_q <= `VPS_RESP_OKAY;
            rdata_q <= 32'h0;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_q <= 1'h1;
            rresp_q <= `VPS_RESP_OKAY;
            case (reg_sel(s_axi_araddr_in))
                2'h0: rdata_q <= {31'h0, ctrl_q};
                2'h1: rdata_q <= status_v;
                2'h2: rdata_q <= {25'h0, vid_acc_q};
                default: begin
                    rdata_q <= 32'h0;
                    rresp_q <= `VPS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_q <= 1'h0;
        end
    end

    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rdata_out = rdata_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    property p_vid_hold;
        vid_chg |=> !hold_done [*7];
    endproperty
    a_vid_hold: assert property (p_vid_hold) else $error("code taken too early");

    property p_mask_restart;
        vid_chg |=> mask_busy;
    endproperty
    a_mask_restart: assert property (p_mask_restart) else $error("mask not restarted");

    property p_force_pwm;
        transient |=> !rpm_q && dual_q && !dcm_q;
    endproperty
    a_force_pwm: assert property (p_force_pwm) else $error("ripple mode in transient");

    property p_ovp_drive;
        (st_q == VPS_ST_OVP && !rvp_q) |=> !hs_v[0] && !hs_v[1] && ls_v[0] && ls_v[1];
    endproperty
    a_ovp_drive: assert property (p_ovp_drive) else $error("crowbar drive wrong");

    property p_ovp_latch;
        (st_q == VPS_ST_OVP && en_s && !cmp_s.supply_uv) |=> st_q == VPS_ST_OVP;
    endproperty
    a_ovp_latch: assert property (p_ovp_latch) else $error("latch released");

    property p_ovp_off;
        (cmp_s.tt_disable && st_q != VPS_ST_OVP) |=> st_q != VPS_ST_OVP;
    endproperty
    a_ovp_off: assert property (p_ovp_off) else $error("trip while disabled");

    property p_rvp_drive;
        rvp_q |=> !hs_v[0] && !hs_v[1] && !ls_v[0] && !ls_v[1];
    endproperty
    a_rvp_drive: assert property (p_rvp_drive) else $error("drive during reverse");

    property p_rvp_hold;
        (rvp_q && !cmp_s.rvp_exit && st_q != VPS_ST_OFF) |=> rvp_q;
    endproperty
    a_rvp_hold: assert property (p_rvp_hold) else $error("reverse left early");

    property p_shutdown;
        (st_q == VPS_ST_OFF) |=> dis_q && !hs_v[0] && !ls_v[0] && !pg_q;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown outputs wrong");

    property p_therm;
        cmp_s.therm_hi |=> thermal_alarm_out;
    endproperty
    a_therm: assert property (p_therm) else $error("alarm missing");

    property p_current_limit_set;
        cmp_s.current_limit_set_over |=> current_limit_out;
    endproperty
    a_current_limit_set: assert property (p_current_limit_set) else $error("limit flag missing");

    c_vid_take: cover property (vid_chg ##[1:20] hold_done);
    c_ovp: cover property (st_q == VPS_ST_RUN ##1 st_q == VPS_ST_OVP);
    c_rvp: cover property (rvp_q && st_q == VPS_ST_OVP);
    c_dcm: cover property (dcm_q && g_ph[0].zc_q);
endmodule

// [hdl/vps_sync.sv]
`timescale 1ns/100ps
module vps_sync #(
    parameter int unsigned W = 8
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// [hdl/vps_timer.sv]
`timescale 1ns/100ps
module vps_timer #(
    parameter int unsigned W = 12
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [W-1:0] load_in,
    output logic busy_out,
    output logic done_out
);
    logic [W-1:0] cnt_q;

    // Start always reloads, so a retrigger restarts from the top
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_q <= '0;
        end else if (start_in) begin
            cnt_q <= load_in;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign busy_out = (cnt_q != '0);
    assign done_out = (cnt_q == W'(1)) && !start_in;
endmodule

// [verif/vps_cpu_model.sv]
`timescale 1ns/100ps
// ----
// Processor code stepper
// ----
module vps_cpu_model (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [6:0] target_in,
    input wire logic [7:0] gap_in,
    output logic [6:0] code_out,
    output logic busy_out
);
    logic [7:0] wait_q;
    assign busy_out = (code_out != target_in) || (wait_q != 8'h00);
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            code_out <= 7'h00;
            wait_q <= 8'h00;
        end else if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
        end else if (code_out != target_in) begin
            code_out <= (target_in > code_out) ? code_out + 7'h01 : code_out - 7'h01;
            wait_q <= gap_in;
        end
    end
endmodule

// [verif/vps_seq_test.sv]
`timescale 1ns/100ps
module vps_seq_test;
    import vps_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd, rdata;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awr, wr, bv, arr, rv, busy, sleep = 1'b0, en = 1'b0;
    logic [1:0] bresp, rresp, resp, pwm = 2'h0;
    logic [6:0] code, target = 7'h00;
    logic [7:0] gap = 8'h14;
    logic hs_a, hs_b, ls_a, ls_b, ripple_regulation_mode, dual, alarm, current_limit_set, ss_d, pg_d, pg_n, pg_dat;
    vps_cmp_t cmp = '0;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    wire [11:0] pins = {hs_a, hs_b, ls_a, ls_b, ripple_regulation_mode, dual, alarm, current_limit_set, ss_d, pg_d, pg_n, pg_dat};
    vps_seq uut (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rready), .voltage_id_code_in(code), .deeper_sleep_select_in(sleep),
        .enable_in(en), .cmp_in(cmp), .pwm_in(pwm), .power_good_in(pg_n),
        .power_good_data_out(pg_dat), .power_good_oe_n_out(pg_n),
        .high_side_gate_drive_a_out(hs_a), .high_side_gate_drive_b_out(hs_b),
        .low_side_gate_drive_a_out(ls_a), .low_side_gate_drive_b_out(ls_b),
        .ripple_regulation_mode_out(ripple_regulation_mode), .dual_phase_out(dual), .thermal_alarm_out(alarm),
        .current_limit_out(current_limit_set), .soft_start_discharge_out(ss_d),
        .power_good_delay_discharge_out(pg_d));
    vps_cpu_model cpu (.core_clk_in(clk), .rst_in(rst), .target_in(target), .gap_in(gap),
        .code_out(code), .busy_out(busy));
    // ----
    // Helpers
    // ----
    initial forever #25 clk = ~clk;
    function automatic logic exp_rpm(input logic multi, input logic slp, input logic trans);
        return (!multi || slp) && !trans;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [11:0] m, input logic [11:0] e);
        total_checks++;
        if ((pins & m) !== e) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, pins & m, e);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wr));
        do @(posedge clk); while (bv !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            wrap_up();
        end
    end
    // ----
    // Tests
    // ----
    initial begin
        rd = $urandom(68395);
        run(20);
        rst <= 1'b0;
        run(1);
        chk_pin(12'hf0f, 12'h00c);
        rd_reg(32'h0, rd);
        chk(rd, 32'h0);
        rd_reg(32'h10, rd);
        chk({30'h0, resp}, 32'h2);
        cmp.supply_ok <= 1'b1;
        cmp.rvp_exit <= 1'b1;
        en <= 1'b1;
        pwm <= 2'h3;
        run(6);
        rd_reg(32'h4, rd);
        chk(rd & 32'h3, 32'h1);
        chk_pin(12'hf8c, {4'h8, exp_rpm(1'b0, 1'b0, 1'b0), 7'h00});
        pwm <= 2'h0;
        run(4);
        chk_pin(12'hf00, 12'h200);
        $display("start test done");
        sleep <= 1'b1;
        run(5);
        chk_pin(12'h0c0, 12'h040);
        run(2700);
        cmp.light_load <= 1'b1;
        cmp.zero_cross <= 2'h3;
        run(5);
        chk_pin(12'hfc0, {4'h0, exp_rpm(1'b0, 1'b1, 1'b0), 7'h00});
        cmp.light_load <= 1'b0;
        cmp.zero_cross <= 2'h0;
        pwm <= 2'h3;
        run(3);
        pwm <= 2'h0;
        run(4);
        chk_pin(12'hf00, 12'h200);
        sleep <= 1'b0;
        run(2700);
        target <= 7'h03;
        run(6);
        chk_pin(12'h0c0, 12'h040);
        rd_reg(32'h8, rd);
        chk(rd, 32'h0);
        do run(1); while (busy);
        run(12);
        rd_reg(32'h8, rd);
        chk(rd, 32'h3);
        run(1900);
        target <= 7'h04;
        run(2000);
        chk_pin(12'h080, 12'h000);
        run(700);
        chk_pin(12'h080, {4'h0, exp_rpm(1'b0, 1'b0, 1'b0), 7'h00});
        cmp.pg_upper_ok <= 1'b1;
        run(5);
        chk_pin(12'h002, 12'h000);
        cmp.pg_lower_ok <= 1'b1;
        run(5);
        chk_pin(12'h002, 12'h002);
        $display("code test done");
        wr_reg(32'h0, 32'h1);
        chk({30'h0, resp}, 32'h0);
        rd_reg(32'h0, rd);
        chk(rd, 32'h1);
        cmp.light_load <= 1'b1;
        cmp.current_limit_set_over <= 1'b1;
        run(5);
        chk_pin(12'h050, 12'h050);
        cmp.current_limit_set_over <= 1'b0;
        run(5);
        rd_reg(32'h4, rd);
        chk(rd & 32'h70, 32'h40);
        run(2100);
        rd_reg(32'h4, rd);
        chk(rd & 32'h40, 32'h0);
        cmp.light_load <= 1'b0;
        wr_reg(32'h0, 32'h0);
        cmp.therm_hi <= 1'b1;
        run(5);
        chk_pin(12'h020, 12'h020);
        cmp.therm_hi <= 1'b0;
        run(5);
        chk_pin(12'h020, 12'h020);
        cmp.therm_lo <= 1'b1;
        run(5);
        chk_pin(12'h020, 12'h000);
        cmp.therm_lo <= 1'b0;
        pwm <= 2'h3;
        cmp.tt_disable <= 1'b1;
        cmp.ovp_trip <= 1'b1;
        run(5);
        chk_pin(12'hf00, 12'h800);
        cmp.tt_disable <= 1'b0;
        run(5);
        chk_pin(12'hf00, 12'h300);
        cmp.ovp_trip <= 1'b0;
        run(5);
        rd_reg(32'h4, rd);
        chk(rd & 32'h3, 32'h3);
        cmp.rvp_enter <= 1'b1;
        cmp.rvp_exit <= 1'b0;
        run(5);
        chk_pin(12'hf00, 12'h000);
        cmp.rvp_enter <= 1'b0;
        run(5);
        chk_pin(12'hf00, 12'h000);
        cmp.rvp_exit <= 1'b1;
        run(5);
        chk_pin(12'hf00, 12'h300);
        en <= 1'b0;
        run(5);
        chk_pin(12'hf0c, 12'h00c);
        en <= 1'b1;
        run(6);
        rd_reg(32'h4, rd);
        chk(rd & 32'h3, 32'h1);
        cmp.rvp_enter <= 1'b1;
        cmp.rvp_exit <= 1'b0;
        run(5);
        chk_pin(12'hf00, 12'h000);
        cmp.rvp_enter <= 1'b0;
        cmp.rvp_exit <= 1'b1;
        run(5);
        chk_pin(12'hf00, 12'h800);
        cmp.supply_uv <= 1'b1;
        run(5);
        chk_pin(12'hf0c, 12'h00c);
        cmp.supply_uv <= 1'b0;
        $display("protect test done");
        for (int i = 0; i < 4; i++) begin
            target <= target ^ 7'($urandom % 8);
            gap <= 8'($urandom % 20 + 10);
            run(2);
            do run(1); while (busy);
            run(12);
            rd_reg(32'h8, rd);
            chk(rd, {25'h0, target});
        end
        $display("random test done");
        wrap_up();
    end
endmodule
